// >>> core/clock_control_pkg.sv
// Purpose: Constants for the system clock divider control block
// Assumes: mclk is the main oscillator clock
// Notes:   Warm-up lengths are in main-clock periods
package clock_control_pkg;
   localparam logic [7:0] ctrl_reset     = 8'h00;
   localparam int         gate_bit       = 7;
   localparam int         halt_bit       = 6;
   localparam int         sel_hi         = 5;
   localparam int         sel_lo         = 3;
   localparam int         test_bit       = 2;
   localparam int         warm_hi        = 1;
   localparam int         warm_lo        = 0;
   localparam logic [2:0] sel_main_div32 = 3'h0;
   localparam logic [2:0] sel_main_div2  = 3'h4;
   localparam logic [2:0] sel_sub_div2   = 3'h7;
   // Longest warm-up is 2^18 periods; each select step halves it
   localparam int         warm_exp_max   = 18;
   localparam int         main_div_bits  = 5;
   localparam int         main_taps      = 10;
   localparam int         sub_taps       = 8;
   typedef enum logic [1:0] {st_run, st_stopped, st_warmup} clk_state_e;
endpackage

// >>> core/system_clock_divider_control.sv
// Purpose: System clock select, stop/warm-up sequencing and prescalers
// Assumes: STOP and wake events come as one-cycle pulses on mclk
// Notes:   sub_clk_in is asynchronous and is synchronised before use
//          Reserved select codes keep the divider already in force
//          Main halt bit is an output only; mclk itself keeps running
// What this block does
// - Select field picks main/32..main/2 or sub/2
// - After reset run from main clock divided 32
// - Reset clears control register to zero
// - Top bit gates any system speed change
// - New select applies only on gated STOP
// - Bit six drives the main_osc_halt output
// - Wake waits 2^18..2^15 main periods by bits
// - Main prescaler ten taps, sub prescaler eight
`timescale 1ns/10ps
module system_clock_divider_control #(
   parameter int warm_exp_max = clock_control_pkg::warm_exp_max
) (
   input  wire logic                                   mclk,
   input  wire logic                                   resetn,
   input  wire logic                                   ctrl_wr,
   input  wire logic [7:0]                             ctrl_wdata,
   input  wire logic                                   stop_exec,
   input  wire logic                                   stop_release,
   input  wire logic                                   sub_clk_in,
   output logic      [7:0]                             ctrl_rdata,
   output logic                                        sys_clk,
   output logic                                        cpu_run,
   output logic                                        main_osc_halt,
   output logic      [clock_control_pkg::main_taps-1:0] main_prescaler_taps,
   output logic      [clock_control_pkg::sub_taps-1:0]  sub_prescaler_taps
);
   localparam int warm_w = warm_exp_max + 1;

   logic [7:0]                                    clock_change_control_reg;
   logic [2:0]                                    active_sel_reg;
   logic [2:0]                                    pending_sel_reg;
   logic                                          pending_valid_reg;
   clock_control_pkg::clk_state_e                 state_reg;
   logic [warm_w-1:0]                             warm_cnt_reg;
   logic [clock_control_pkg::main_div_bits-1:0]   main_div_reg;
   logic [clock_control_pkg::main_taps:0]         main_pre_reg;
   logic [clock_control_pkg::sub_taps-1:0]        sub_pre_reg;
   logic                                          sub_half_reg;
   logic                                          sub_sync1_reg;
   logic                                          sub_sync2_reg;
   logic                                          sub_prev_reg;

   // Legal select codes only; reserved codes leave the old divider
   function automatic logic sel_legal(input logic [2:0] s);
      return (s <= clock_control_pkg::sel_main_div2) || (s == clock_control_pkg::sel_sub_div2);
   endfunction

   // Warm-up length in mclk periods; each select step halves it
   function automatic logic [warm_w-1:0] warm_length(input logic [1:0] w);
      return warm_w'(1) << (warm_exp_max - int'(w));
   endfunction

   wire logic [2:0]        sel_field  = clock_change_control_reg[clock_control_pkg::sel_hi:clock_control_pkg::sel_lo];
   wire logic [1:0]        warm_field = clock_change_control_reg[clock_control_pkg::warm_hi:clock_control_pkg::warm_lo];
   wire logic              gate_on    = clock_change_control_reg[clock_control_pkg::gate_bit];
   wire logic              sub_rise   = sub_sync2_reg & ~sub_prev_reg;
   wire logic [warm_w-1:0] warm_len   = warm_length(warm_field);
   wire logic              warm_done  = (state_reg == clock_control_pkg::st_warmup) && (warm_cnt_reg == warm_len - 1'b1);
   wire logic [2:0]        div_index  = 3'(clock_control_pkg::sel_main_div2 - active_sel_reg);
   wire logic              main_tap   = main_div_reg[div_index];
   wire logic              sel_is_sub = (active_sel_reg == clock_control_pkg::sel_sub_div2);
   wire logic              run_next   = (state_reg == clock_control_pkg::st_run) && !stop_exec;
   wire logic              clk_next   = !run_next ? 1'b0 : (sel_is_sub ? sub_half_reg : main_tap);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         clock_change_control_reg <= clock_control_pkg::ctrl_reset;
      end else if (ctrl_wr) begin
         clock_change_control_reg <= ctrl_wdata;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_reg         <= clock_control_pkg::st_run;
         active_sel_reg    <= clock_control_pkg::sel_main_div32;
         pending_sel_reg   <= clock_control_pkg::sel_main_div32;
         pending_valid_reg <= 1'b0;
         warm_cnt_reg      <= '0;
      end else begin
         unique case (state_reg)
            clock_control_pkg::st_run: begin
               // Select and gate are captured at the STOP instant
               if (stop_exec) begin
                  state_reg         <= clock_control_pkg::st_stopped;
                  pending_sel_reg   <= sel_field;
                  pending_valid_reg <= gate_on && sel_legal(sel_field);
               end
            end
            clock_control_pkg::st_stopped: begin
               warm_cnt_reg <= '0;
               if (stop_release) begin
                  state_reg <= clock_control_pkg::st_warmup;
               end
            end
            clock_control_pkg::st_warmup: begin
               warm_cnt_reg <= warm_cnt_reg + 1'b1;
               if (warm_done) begin
                  state_reg         <= clock_control_pkg::st_run;
                  pending_valid_reg <= 1'b0;
                  // Captured select applies only as warm-up ends
                  if (pending_valid_reg) begin
                     active_sel_reg <= pending_sel_reg;
                  end
               end
            end
         endcase
      end
   end

   // Divider restarts at the switch so the first new pulse is full length
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         main_div_reg <= '0;
      end else if (state_reg != clock_control_pkg::st_run) begin
         main_div_reg <= '0;
      end else begin
         main_div_reg <= main_div_reg + 1'b1;
      end
   end

   // Two-stage synchroniser for the asynchronous sub-clock pin
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sub_sync1_reg <= 1'b0;
         sub_sync2_reg <= 1'b0;
         sub_prev_reg  <= 1'b0;
      end else begin
         sub_sync1_reg <= sub_clk_in;
         sub_sync2_reg <= sub_sync1_reg;
         sub_prev_reg  <= sub_sync2_reg;
      end
   end

   // Free-running, also through stop, so peripheral taps never pause
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         main_pre_reg <= '0;
      end else begin
         main_pre_reg <= main_pre_reg + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sub_pre_reg <= '0;
      end else if (sub_rise) begin
         sub_pre_reg <= sub_pre_reg + 1'b1;
      end
   end

   // Sub/2 source toggles on each synchronised sub-clock rising edge
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sub_half_reg <= 1'b0;
      end else if (sub_rise) begin
         sub_half_reg <= ~sub_half_reg;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl_rdata <= clock_control_pkg::ctrl_reset;
      end else begin
         ctrl_rdata <= clock_change_control_reg;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sys_clk <= 1'b0;
      end else begin
         sys_clk <= clk_next;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cpu_run <= 1'b1;
      end else begin
         cpu_run <= run_next;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         main_osc_halt <= 1'b0;
      end else begin
         main_osc_halt <= clock_change_control_reg[clock_control_pkg::halt_bit];
      end
   end

   // One registered output flop per main prescaler tap
   for (genvar t = 0; t < clock_control_pkg::main_taps; t++) begin : g_main_tap
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            main_prescaler_taps[t] <= 1'b0;
         end else begin
            main_prescaler_taps[t] <= main_pre_reg[t+1];
         end
      end
   end

   // One registered output flop per sub prescaler tap
   for (genvar u = 0; u < clock_control_pkg::sub_taps; u++) begin : g_sub_tap
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            sub_prescaler_taps[u] <= 1'b0;
         end else begin
            sub_prescaler_taps[u] <= sub_pre_reg[u];
         end
      end
   end
endmodule

// >>> verification/system_clock_divider_control_properties.sv
// Purpose: Port checks for system_clock_divider_control
// Assumes: Warm-up never shorter than 8 cycles
// Notes:   Bound to every instance of the block
`timescale 1ns/10ps
module system_clock_divider_control_properties #(
   parameter int warm_exp_max = 18
) (
   input wire logic       mclk,
   input wire logic       resetn,
   input wire logic       ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   input wire logic       stop_exec,
   input wire logic       stop_release,
   input wire logic       sub_clk_in,
   input wire logic [7:0] ctrl_rdata,
   input wire logic       sys_clk,
   input wire logic       cpu_run,
   input wire logic       main_osc_halt,
   input wire logic [9:0] main_prescaler_taps,
   input wire logic [7:0] sub_prescaler_taps
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   property p_rdback; ctrl_wr |-> ##2 ctrl_rdata == $past(ctrl_wdata, 2); endproperty
   a_rdback: assert property (p_rdback) else $error("readback differs from write");
   property p_halt; ctrl_wr |-> ##2 main_osc_halt == $past(ctrl_wdata[6], 2); endproperty
   a_halt: assert property (p_halt) else $error("halt output differs");
   property p_stop; cpu_run && stop_exec |=> !cpu_run && !sys_clk; endproperty
   a_stop: assert property (p_stop) else $error("clock not gated at stop");
   property p_hold; $fell(cpu_run) |-> !cpu_run [*8]; endproperty
   a_hold: assert property (p_hold) else $error("cpu resumed too soon");
   property p_low; !cpu_run |-> !sys_clk; endproperty
   a_low: assert property (p_low) else $error("clock runs while stopped");
   property p_tap; $rose(main_prescaler_taps[0]) |=> main_prescaler_taps[0] ##1 !main_prescaler_taps[0]; endproperty
   a_tap: assert property (p_tap) else $error("first main tap not mclk/4");
   property p_sub; $changed(sub_prescaler_taps) |-> sub_prescaler_taps == 8'($past(sub_prescaler_taps) + 1); endproperty
   a_sub: assert property (p_sub) else $error("sub prescaler skipped");
   property p_wide; $rose(sys_clk) ##1 cpu_run ##1 cpu_run |-> sys_clk || $past(sys_clk); endproperty
   a_wide: assert property (p_wide) else $error("short clock pulse");
endmodule
bind system_clock_divider_control system_clock_divider_control_properties #(.warm_exp_max(warm_exp_max)) chk_i (.*);

// >>> verification/system_clock_divider_control_tb.sv
// Purpose: Random and corner tests of system_clock_divider_control
// Assumes: Sub clock period is 10 mclk cycles
// Notes:   Warm-up shortened to 64/32/16/8 cycles
`timescale 1ns/10ps
module system_clock_divider_control_tb;
   logic mclk = 0, resetn = 0, ctrl_wr = 0, stop_exec = 0, stop_release = 0, sub_clk_in = 0;
   logic [7:0] ctrl_wdata = 8'h00, ctrl_rdata, d, sub_tap;
   logic sys_clk, cpu_run, main_osc_halt;
   logic [9:0] main_tap;
   logic [2:0] cur = 3'h0;
   logic [2:0] codes [10] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h0, 3'h5, 3'h6, 3'h4, 3'h4};
   int seed = 50661, n_errors = 0, checks = 0, i, p, w, off = -1;
   system_clock_divider_control #(.warm_exp_max(6)) system_clock_divider_control_i (.mclk(mclk), .resetn(resetn),
      .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .stop_exec(stop_exec), .stop_release(stop_release),
      .sub_clk_in(sub_clk_in), .ctrl_rdata(ctrl_rdata), .sys_clk(sys_clk), .cpu_run(cpu_run),
      .main_osc_halt(main_osc_halt), .main_prescaler_taps(main_tap), .sub_prescaler_taps(sub_tap));
   always #4 mclk = ~mclk;
   initial forever begin repeat (5) @(posedge mclk); sub_clk_in <= ~sub_clk_in; end
   function automatic int exp_per(input logic [2:0] c);
      return (c == 3'h7) ? 20 : (1 << (5 - c));
   endfunction
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin n_errors++; $display("wrong value %s exp %h got %h", nm, e, g); end
   endtask
   task wr(input logic [7:0] v);
      @(posedge mclk) begin ctrl_wr <= 1; ctrl_wdata <= v; end
      @(posedge mclk) ctrl_wr <= 0;
   endtask
   task per(output int q);
      int k, j;
      logic pr;
      q = 0; k = 0; pr = 1;
      for (j = 0; j < 400 && k < 2; j++) begin
         @(posedge mclk); #1;
         if (sys_clk === 1'b1 && !pr) k++;
         if (k == 1) q++;
         pr = (sys_clk === 1'b1);
      end
   endtask
   task give_verdict;
      if (n_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin repeat (30000) @(posedge mclk); n_errors++; give_verdict; end
   initial begin
      repeat (12) @(posedge mclk);
      resetn <= 1;
      @(posedge mclk); #1 chk("ctrl_rdata", 8'h00, ctrl_rdata);
      per(p); chk("reset period", 8'(exp_per(3'h0)), 8'(p));
      for (i = 0; i < 10; i++) begin
         d = {i != 8, codes[i] == 3'h7, codes[i], 1'b0, 2'($random(seed))};
         wr(d);
         @(posedge mclk) stop_exec <= 1;
         @(posedge mclk) stop_exec <= 0;
         repeat (3) @(posedge mclk);
         @(posedge mclk) stop_release <= 1;
         @(posedge mclk) stop_release <= 0;
         for (w = 1; w < 200 && cpu_run !== 1'b1; w++) @(posedge mclk);
         if (off < 0) off = w - (1 << (6 - d[1:0]));
         chk("warm-up", 8'(off + (1 << (6 - d[1:0]))), 8'(w));
         if (d[7] && (d[5:3] <= 3'h4 || d[5:3] == 3'h7)) cur = d[5:3];
         per(p); chk("sys period", 8'(exp_per(cur)), 8'(p));
      end
      for (i = 0; i < 6; i++) begin
         d = 8'($random(seed)) & 8'hfb;
         wr(d);
         @(posedge mclk); #1 chk("ctrl_rdata", d, ctrl_rdata);
         chk("main_osc_halt", {7'h00, d[6]}, {7'h00, main_osc_halt});
      end
      give_verdict;
   end
endmodule
